/* rtl/pmt_pkg.sv */
/*
 * Shared constants for the telemetry and status readback block:
 * command codes, bit positions, exponent values, readout slots and link states.
 * Assumes a single-slave serial management link with seven-bit addressing.
 */
package pmt_pkg;
	// command codes served by the block
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
	localparam logic [7:0] CMD_STATUS_CML   = 8'h7E;
	localparam logic [7:0] CMD_MFR_STATUS   = 8'h80;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_READING     = 8'h88;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING    = 8'h8B;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_READING    = 8'h8C;
	localparam logic [7:0] CMD_READ_TEXT    = 8'h8D;
	localparam logic [7:0] CMD_READ_TDIE    = 8'h8E;

	// seven-bit slave address of this device
	localparam logic [6:0] DEV_ADDR = 7'h20;

	// field positions
	localparam int MFR_WARN_BIT    = 6;
	localparam int MFR_FAULT_BIT   = 7;
	localparam int CML_BAD_CMD_BIT = 7;
	localparam int WORD_VENDOR_BIT = 12;
	localparam int WORD_CML_BIT    = 1;

	// linear-format exponents, two's complement
	localparam logic [4:0] EXP_VIN  = 5'h1E;
	localparam logic [4:0] EXP_LOAD_CURRENT_VALUE = 5'h1D;
	localparam logic [4:0] EXP_TEXT = 5'h00;
	localparam logic [4:0] EXP_TDIE = 5'h00;

	// readout slots of the snapshot bank
	localparam int          NUM_SLOTS    = 8;
	localparam logic [2:0]  SLOT_WORD    = 3'h0;
	localparam logic [2:0]  SLOT_CML     = 3'h1;
	localparam logic [2:0]  SLOT_MFR     = 3'h2;
	localparam logic [2:0]  SLOT_VIN     = 3'h3;
	localparam logic [2:0]  SLOT_RAIL_OUT_VALUE    = 3'h4;
	localparam logic [2:0]  SLOT_LOAD_CURRENT_VALUE    = 3'h5;
	localparam logic [2:0]  SLOT_TEXT    = 3'h6;
	localparam logic [2:0]  SLOT_TDIE    = 3'h7;
	localparam logic [15:0] SNAP_RESET   = 16'h0000;
	localparam logic [15:0] UNSUPP_WORD  = 16'hFFFF;

	// crossing filter depth and last bit index of a byte
	localparam int         SYNC_STAGES = 3;
	localparam logic [2:0] LAST_BIT    = 3'h7;

	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_CMD, LK_CMD_ACK,
		LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RDATA_ACK
	} pmt_link_state_t;
endpackage

/* rtl/pmt_telemetry.sv */
/*
 * Telemetry and status readback over the serial management link.
 * Core side holds sticky flags and a snapshot bank of status and measurement words;
 * link side runs on the serial clock and serves reads out of the frozen bank.
 * Assumes open-drain data wiring outside and telemetry inputs on the core clock.
 */
// Operation
// R1: status byte bit 6 flags die overheat warning
// R2: status byte bit 7 flags die overheat fault
// R3: command 88 returns input voltage, linear format
// R4: command 8B returns output voltage mantissa only
// R5: command 8C returns output current, linear format
// R6: command 8D returns external temperature, linear
// R7: command 8E returns die temperature, linear
// R8: unsupported command or write sets bad-command flag
// R9: vendor summary bit follows any vendor flag
// R10: five-bit exponent above eleven-bit mantissa
`timescale 1ns/100ps
module pmt_telemetry
	import pmt_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	input  wire logic        i_die_overheat_warning,
	input  wire logic        i_die_overheat_fault,
	input  wire logic [10:0] i_supply_in_value,
	input  wire logic [15:0] i_rail_out_value,
	input  wire logic [10:0] i_load_current_value,
	input  wire logic [10:0] i_external_sensor_value,
	input  wire logic [10:0] i_die_sensor_value,
	output logic             o_bad_command_flag,
	output logic             o_vendor_summary_flag
);
	// map a command code to {served, slot}
	function automatic logic [3:0] cmd_slot(input logic [7:0] cmd);
		case (cmd)
			CMD_STATUS_WORD: cmd_slot = {1'b1, SLOT_WORD};
			CMD_STATUS_CML:  cmd_slot = {1'b1, SLOT_CML};
			CMD_MFR_STATUS:  cmd_slot = {1'b1, SLOT_MFR};
			CMD_INPUT_VOLTAGE_READING:    cmd_slot = {1'b1, SLOT_VIN};
			CMD_OUTPUT_VOLTAGE_READING:   cmd_slot = {1'b1, SLOT_RAIL_OUT_VALUE};
			CMD_OUTPUT_CURRENT_READING:   cmd_slot = {1'b1, SLOT_LOAD_CURRENT_VALUE};
			CMD_READ_TEXT:   cmd_slot = {1'b1, SLOT_TEXT};
			CMD_READ_TDIE:   cmd_slot = {1'b1, SLOT_TDIE};
			default:         cmd_slot = 4'h0;
		endcase
	endfunction
	// frame markers, clocked by the data line itself
	logic        open_mark_reg, stop_mark_reg, start_tgl_reg, frame_active;
	// link registers and their next values
	pmt_link_state_t state_reg, state_next;
	logic [2:0]  bit_cnt_reg, bit_cnt_next;
	logic [7:0]  shift_reg, shift_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic [15:0] rd_word_reg, rd_word_next;
	logic        hi_byte_reg, hi_byte_next;
	logic        rw_reg, rw_next;
	logic        start_seen_reg, start_seen_next;
	logic        err_tgl_reg, err_tgl_next;
	logic        clr_tgl_reg, clr_tgl_next;
	logic        sda_drv_reg, sda_drv_next;
	logic [7:0]  rx_byte;
	logic [3:0]  rx_slot, cur_slot;
	// core registers and their next values
	logic [2:0]  sync0_reg, sync1_reg, sync2_reg;
	logic [2:0]  filt_reg, filt_next;
	logic        warn_reg, warn_next;
	logic        fault_reg, fault_next;
	logic        cml_reg, cml_next;
	logic        summary_reg, summary_next;
	logic [15:0] snap_reg [NUM_SLOTS];
	logic [15:0] snap_next [NUM_SLOTS];
	logic        err_ev, clr_ev;
	// start: data falls while clock high; stop: data rises while clock high
	always_ff @(negedge i_sda) begin
		open_mark_reg <= !i_nrst ? 1'b0 : (i_scl ? ~stop_mark_reg : open_mark_reg);
		start_tgl_reg <= !i_nrst ? 1'b0 : (i_scl ? ~start_tgl_reg : start_tgl_reg);
	end
	always_ff @(posedge i_sda) begin
		stop_mark_reg <= !i_nrst ? 1'b0 : (i_scl ? open_mark_reg : stop_mark_reg);
	end
	// the clock may stop after a stop condition, so the frame's own marks end it
	assign frame_active = open_mark_reg ^ stop_mark_reg;
	assign rx_byte      = {shift_reg[6:0], i_sda};
	assign rx_slot      = cmd_slot(rx_byte);
	assign cur_slot     = cmd_slot(cmd_reg);
	// link state machine, bits sampled on the rising serial clock
	always_comb begin
		state_next      = state_reg;
		bit_cnt_next    = bit_cnt_reg;
		shift_next      = shift_reg;
		cmd_next        = cmd_reg;
		rd_word_next    = rd_word_reg;
		hi_byte_next    = hi_byte_reg;
		rw_next         = rw_reg;
		err_tgl_next    = err_tgl_reg;
		clr_tgl_next    = clr_tgl_reg;
		start_seen_next = start_tgl_reg;
		if (start_tgl_reg != start_seen_reg) begin
			// this edge carries the first address bit
			state_next   = LK_ADDR;
			shift_next   = {7'h00, i_sda};
			bit_cnt_next = 3'h1;
		end else begin
			case (state_reg)
				LK_ADDR: begin
					shift_next   = rx_byte;
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == LAST_BIT) begin
						rw_next    = i_sda;
						state_next = (shift_reg[6:0] == DEV_ADDR) ? LK_ADDR_ACK : LK_IDLE;
					end
				end
				LK_ADDR_ACK: begin
					bit_cnt_next = 3'h0;
					if (rw_reg) begin
						// served slots are read from the bank frozen for this frame
						rd_word_next = cur_slot[3] ? snap_reg[cur_slot[2:0]]
							: UNSUPP_WORD; // [R3] [R4] [R5] [R6] [R7]
						shift_next   = rd_word_next[7:0]; // low byte first
						hi_byte_next = 1'b0;
						state_next   = LK_RDATA;
					end else begin
						state_next = LK_CMD;
					end
				end
				LK_CMD: begin
					shift_next   = rx_byte;
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == LAST_BIT) begin
						cmd_next   = rx_byte;
						state_next = LK_CMD_ACK;
						if (rx_byte == CMD_CLEAR_FAULTS) begin
							clr_tgl_next = ~clr_tgl_reg;
						end else if (!rx_slot[3]) begin
							err_tgl_next = ~err_tgl_reg; // [R8]
						end
					end
				end
				LK_CMD_ACK, LK_WDATA_ACK: begin
					bit_cnt_next = 3'h0;
					state_next   = LK_WDATA;
				end
				LK_WDATA: begin
					shift_next   = rx_byte;
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == LAST_BIT) begin
						err_tgl_next = ~err_tgl_reg; // no command here takes a data byte [R8]
						state_next   = LK_WDATA_ACK;
					end
				end
				LK_RDATA: begin
					shift_next   = {shift_reg[6:0], 1'b0};
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == LAST_BIT) begin
						state_next = LK_RDATA_ACK;
					end
				end
				LK_RDATA_ACK: begin
					bit_cnt_next = 3'h0;
					hi_byte_next = 1'b1;
					shift_next   = hi_byte_reg ? 8'hFF : rd_word_reg[15:8];
					state_next   = i_sda ? LK_IDLE : LK_RDATA; // nack ends the read
				end
				default: begin
					state_next = LK_IDLE;
				end
			endcase
		end
	end
	// synchronous reset, seen only while the serial clock still moves
	always_ff @(posedge i_scl) begin
		state_reg      <= i_nrst ? state_next : LK_IDLE;
		bit_cnt_reg    <= i_nrst ? bit_cnt_next : 3'h0;
		shift_reg      <= i_nrst ? shift_next : 8'h00;
		cmd_reg        <= i_nrst ? cmd_next : 8'h00;
		rd_word_reg    <= i_nrst ? rd_word_next : SNAP_RESET;
		hi_byte_reg    <= i_nrst ? hi_byte_next : 1'b0;
		rw_reg         <= i_nrst ? rw_next : 1'b0;
		start_seen_reg <= i_nrst ? start_seen_next : 1'b0;
		err_tgl_reg    <= i_nrst ? err_tgl_next : 1'b0;
		clr_tgl_reg    <= i_nrst ? clr_tgl_next : 1'b0;
	end
	// data line changes only while the clock is low: acks and read bits
	always_comb begin
		case (state_reg)
			LK_ADDR_ACK, LK_CMD_ACK, LK_WDATA_ACK: sda_drv_next = 1'b1;
			LK_RDATA:                              sda_drv_next = ~shift_reg[7];
			default:                               sda_drv_next = 1'b0;
		endcase
	end
	always_ff @(negedge i_scl) begin
		sda_drv_reg <= i_nrst ? sda_drv_next : 1'b0;
	end
	// open drain: only ever pull low
	assign o_sda    = 1'b0;
	assign o_sda_oe = sda_drv_reg;
	// three-stage crossing of {clear toggle, error toggle, frame busy}
	always_ff @(posedge i_clk) begin
		sync0_reg <= i_nrst ? {clr_tgl_reg, err_tgl_reg, frame_active} : 3'h0;
		sync1_reg <= i_nrst ? sync0_reg : 3'h0;
		sync2_reg <= i_nrst ? sync1_reg : 3'h0;
	end
	// core flags and snapshot; the bank freezes while a frame is open
	always_comb begin
		filt_next    = (sync2_reg & ~(sync1_reg ^ sync2_reg)) | (filt_reg & (sync1_reg ^ sync2_reg));
		err_ev       = filt_next[1] ^ filt_reg[1];
		clr_ev       = filt_next[2] ^ filt_reg[2];
		// a new event wins over a clear in the same cycle
		warn_next    = i_die_overheat_warning | (warn_reg & ~clr_ev); // [R1]
		fault_next   = i_die_overheat_fault | (fault_reg & ~clr_ev); // [R2]
		cml_next     = err_ev | (cml_reg & ~clr_ev); // [R8]
		summary_next = warn_reg | fault_reg; // [R9]
		for (int i = 0; i < NUM_SLOTS; i++) begin
			snap_next[i] = snap_reg[i];
		end
		if (!filt_reg[0]) begin
			snap_next[SLOT_WORD] = 16'h0000;
			snap_next[SLOT_WORD][WORD_VENDOR_BIT] = warn_reg | fault_reg; // [R9]
			snap_next[SLOT_WORD][WORD_CML_BIT]    = cml_reg;
			snap_next[SLOT_CML]  = 16'h0000;
			snap_next[SLOT_CML][CML_BAD_CMD_BIT]  = cml_reg; // [R8]
			snap_next[SLOT_MFR]  = 16'h0000; // unsupported bits read zero [R2]
			snap_next[SLOT_MFR][MFR_WARN_BIT]     = warn_reg; // [R1]
			snap_next[SLOT_MFR][MFR_FAULT_BIT]    = fault_reg; // [R2]
			snap_next[SLOT_VIN]  = {EXP_VIN, i_supply_in_value}; // [R3] [R10]
			snap_next[SLOT_RAIL_OUT_VALUE] = i_rail_out_value; // [R4]
			snap_next[SLOT_LOAD_CURRENT_VALUE] = {EXP_LOAD_CURRENT_VALUE, i_load_current_value}; // [R5] [R10]
			snap_next[SLOT_TEXT] = {EXP_TEXT, i_external_sensor_value}; // [R6] [R10]
			snap_next[SLOT_TDIE] = {EXP_TDIE, i_die_sensor_value}; // [R7] [R10]
		end
	end
	always_ff @(posedge i_clk) begin
		filt_reg    <= i_nrst ? filt_next : 3'h0;
		warn_reg    <= i_nrst ? warn_next : 1'b0;
		fault_reg   <= i_nrst ? fault_next : 1'b0;
		cml_reg     <= i_nrst ? cml_next : 1'b0;
		summary_reg <= i_nrst ? summary_next : 1'b0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			snap_reg[i] <= i_nrst ? snap_next[i] : SNAP_RESET;
		end
	end
	assign o_bad_command_flag    = cml_reg;
	assign o_vendor_summary_flag = summary_reg;
	// checks on the core clock only; the link side is exercised by the bench
	default clocking cb_core @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	sequence s_warn_seen;
		i_die_overheat_warning && !filt_reg[0] ##1 !filt_reg[0];
	endsequence
	property p_warn_bit;
		s_warn_seen |=> snap_reg[SLOT_MFR][MFR_WARN_BIT];
	endproperty
	a_warn_bit: assert property (p_warn_bit) else $error("warning bit not shown"); // [R1]
	property p_fault_bit;
		(i_die_overheat_fault && !filt_reg[0]) ##1 !filt_reg[0]
			|=> snap_reg[SLOT_MFR][MFR_FAULT_BIT] && (snap_reg[SLOT_MFR][5:0] == 6'h00);
	endproperty
	a_fault_bit: assert property (p_fault_bit) else $error("fault bit not shown"); // [R2]
	property p_vin_word;
		!filt_reg[0] |=> snap_reg[SLOT_VIN] == {EXP_VIN, $past(i_supply_in_value)};
	endproperty
	a_vin_word: assert property (p_vin_word) else $error("input voltage word wrong"); // [R3]
	property p_rail_out_value_word;
		!filt_reg[0] |=> snap_reg[SLOT_RAIL_OUT_VALUE] == $past(i_rail_out_value);
	endproperty
	a_rail_out_value_word: assert property (p_rail_out_value_word) else $error("output voltage word wrong"); // [R4]
	property p_load_current_value_word;
		!filt_reg[0] |=> snap_reg[SLOT_LOAD_CURRENT_VALUE] == {EXP_LOAD_CURRENT_VALUE, $past(i_load_current_value)};
	endproperty
	a_load_current_value_word: assert property (p_load_current_value_word) else $error("current word wrong"); // [R5]
	property p_text_word;
		!filt_reg[0] |=> snap_reg[SLOT_TEXT] == {EXP_TEXT, $past(i_external_sensor_value)};
	endproperty
	a_text_word: assert property (p_text_word) else $error("external temp wrong"); // [R6]
	property p_tdie_word;
		!filt_reg[0] |=> snap_reg[SLOT_TDIE] == {EXP_TDIE, $past(i_die_sensor_value)};
	endproperty
	a_tdie_word: assert property (p_tdie_word) else $error("die temp word wrong"); // [R7]
	sequence s_err_arrives;
		(sync1_reg[1] != filt_reg[1]) && (sync1_reg[1] == sync2_reg[1]);
	endsequence
	property p_bad_cmd;
		s_err_arrives |=> o_bad_command_flag;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not flagged"); // [R8]
	property p_summary;
		(warn_reg || fault_reg) |=> o_vendor_summary_flag;
	endproperty
	a_summary: assert property (p_summary) else $error("summary flag missing"); // [R9]
endmodule

/* verif/pmt_host_model.sv */
/*
 * Host side of the serial management link: makes the link clock inside frames
 * and in the reset window, and drives data open-drain (1 means released).
 * Assumes the bench resolves the wire from all enables and feeds i_sda.
 */
`timescale 1ns/100ps
module pmt_host_model (
	output logic      o_scl,
	output logic      o_sda,
	input  wire logic i_sda
);
	// idle bus: both lines released to the pull-up level
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// edges for the reset window, with the clock low so no start is seen
	task wiggle;
		#3 o_scl = 1'b0;
		#3 o_sda = 1'b0;
		#3 o_sda = 1'b1;
		#3 o_scl = 1'b1;
		#3 o_scl = 1'b0;
		#3 o_scl = 1'b1;
	endtask

	// start or repeated start: data falls while the clock is high
	task start;
		#3 o_sda = 1'b1;
		#3 o_scl = 1'b1;
		#3 o_sda = 1'b0;
		#3 o_scl = 1'b0;
	endtask

	// one 12 ns bit; data moves only while the clock is low
	task bit_io(input logic b, output logic r);
		#3 o_sda = b;
		#3 o_scl = 1'b1;
		#3 r = i_sda;
		#3 o_scl = 1'b0;
	endtask

	task stop;
		#3 o_sda = 1'b0;
		#3 o_scl = 1'b1;
		#3 o_sda = 1'b1;
		#3;
	endtask

	// byte out, msb first; ack is high when the device pulled data low
	task send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// byte in; last high gives the nack that ends the read
	task recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(last, r);
	endtask
endmodule

/* verif/pmt_telemetry_test.sv */
/*
 * Self-checking bench for the telemetry and status readback block.
 * Assumes the host model above and a pulled-up open-drain data wire.
 */
`timescale 1ns/100ps
module pmt_telemetry_test;
	import pmt_pkg::*;

	logic        i_clk;
	logic        i_nrst;
	logic        scl;
	logic        host_sda;
	wire         sda_line;
	logic        dut_sda;
	logic        dut_oe;
	logic        warn;
	logic        fault;
	logic [10:0] supply_in_value;
	logic [15:0] rail_out_value;
	logic [10:0] load_current_value;
	logic [10:0] text;
	logic [10:0] tdie;
	logic        bad_flag;
	logic        vend_flag;
	logic [15:0] w;
	logic        a;
	int          failures;
	int          cmp_count;

	// wire level: low if either party pulls, else the pull-up
	assign sda_line = host_sda & ~(dut_oe & ~dut_sda);

	// core clock, 8 ns
	always #4 i_clk = ~i_clk;

	pmt_host_model u_host (.o_scl(scl), .o_sda(host_sda), .i_sda(sda_line));

	pmt_telemetry u_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_line),
		.o_sda(dut_sda), .o_sda_oe(dut_oe),
		.i_die_overheat_warning(warn), .i_die_overheat_fault(fault),
		.i_supply_in_value(supply_in_value), .i_rail_out_value(rail_out_value),
		.i_load_current_value(load_current_value), .i_external_sensor_value(text),
		.i_die_sensor_value(tdie), .o_bad_command_flag(bad_flag),
		.o_vendor_summary_flag(vend_flag)
	);

	task give_verdict;
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// bounded wait on a flag; sel 1 is bad command, 0 vendor summary
	task wait_lvl(input int sel, input logic v);
		for (int i = 0; i < 40; i++) begin
			if ((sel ? bad_flag : vend_flag) === v) begin
				return;
			end
			@(posedge i_clk);
		end
		failures++;
		give_verdict;
	endtask

	// word read: command write, repeated start, low then high byte
	task rd(input logic [7:0] cmd, output logic [15:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		u_host.start;
		u_host.send({DEV_ADDR, 1'b0}, a);
		check(a, 1'b1);
		u_host.send(cmd, a);
		check(a, 1'b1);
		u_host.start;
		u_host.send({DEV_ADDR, 1'b1}, a);
		check(a, 1'b1);
		u_host.recv(1'b0, lo);
		u_host.recv(1'b1, hi);
		u_host.stop;
		d = {hi, lo};
	endtask

	// send-byte, or write with one data byte when has_d is set
	task wr(input logic [7:0] cmd, input logic has_d, input logic [7:0] d);
		u_host.start;
		u_host.send({DEV_ADDR, 1'b0}, a);
		check(a, 1'b1);
		u_host.send(cmd, a);
		check(a, 1'b1);
		if (has_d) begin
			u_host.send(d, a);
			check(a, 1'b1);
		end
		u_host.stop;
	endtask

	// one-cycle event pulses; the flags must hold them afterwards
	task pulse(input logic wv, input logic fv);
		@(posedge i_clk);
		#1 warn = wv;
		fault = fv;
		@(posedge i_clk);
		#1 warn = 1'b0;
		fault = 1'b0;
	endtask

	// clear flags and let the cleared state land before the next step
	task clear;
		wr(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
		wait_lvl(0, 1'b0);
		wait_lvl(1, 1'b0);
	endtask

	// main sequence
	initial begin
		i_clk = 1'b0;
		i_nrst = 1'b0;
		{warn, fault} = 2'h0;
		supply_in_value = 11'h123;
		rail_out_value = 16'hA5C3;
		load_current_value = 11'h7FF;
		text = 11'h400;
		tdie = 11'h055;
		failures = 0;
		cmp_count = 0;
		// link edges during reset clear the flops on the link clock
		fork
			u_host.wiggle;
			repeat (4) @(posedge i_clk);
		join
		#1 i_nrst = 1'b1;
		repeat (4) @(posedge i_clk);
		check(bad_flag, 1'b0);
		check(vend_flag, 1'b0);
		// measurements; load_current_value at the top mantissa code
		rd(CMD_INPUT_VOLTAGE_READING, w);
		check(w, {EXP_VIN, supply_in_value});
		rd(CMD_OUTPUT_VOLTAGE_READING, w);
		check(w, rail_out_value);
		rd(CMD_OUTPUT_CURRENT_READING, w);
		check(w, {EXP_LOAD_CURRENT_VALUE, load_current_value});
		rd(CMD_READ_TEXT, w);
		check(w, {EXP_TEXT, text});
		rd(CMD_READ_TDIE, w);
		check(w, {EXP_TDIE, tdie});
		// warning alone, then fault alone, then both
		pulse(1'b1, 1'b0);
		wait_lvl(0, 1'b1);
		rd(CMD_MFR_STATUS, w);
		check(w, 16'h0040);
		rd(CMD_STATUS_WORD, w);
		check(w[WORD_VENDOR_BIT], 1'b1);
		clear;
		pulse(1'b0, 1'b1);
		wait_lvl(0, 1'b1);
		rd(CMD_MFR_STATUS, w);
		check(w, 16'h0080);
		pulse(1'b1, 1'b1);
		rd(CMD_MFR_STATUS, w);
		check(w, 16'h00C0);
		clear;
		// unsupported command read, then a write to a read-only command
		rd(8'h55, w);
		check(w, UNSUPP_WORD);
		wait_lvl(1, 1'b1);
		check(bad_flag, 1'b1);
		rd(CMD_STATUS_CML, w);
		check(w[CML_BAD_CMD_BIT], 1'b1);
		clear;
		wr(CMD_INPUT_VOLTAGE_READING, 1'b1, 8'h12);
		wait_lvl(1, 1'b1);
		check(bad_flag, 1'b1);
		rd(CMD_INPUT_VOLTAGE_READING, w);
		check(w, {EXP_VIN, supply_in_value});
		// foreign address is not acknowledged
		u_host.start;
		u_host.send({7'h21, 1'b0}, a);
		check(a, 1'b0);
		u_host.stop;
		give_verdict;
	end
endmodule
